//--- src/uart_pins_pkg.sv
// Shared constants for the dual serial channel pin logic
`default_nettype none
package uart_pins_pkg;
  // Channel count and register bus geometry
  localparam int NUM_CH = 2;
  localparam int ADDR_W = 6;
  localparam int CH_BIT = 5;
  localparam int LVL_W = 7;
  // Register indices inside one channel's window
  localparam logic [2:0] IDX_MODEM_CTRL = 3'h0;
  localparam logic [2:0] IDX_FEATURE = 3'h1;
  localparam logic [2:0] IDX_IRQ_ENABLE = 3'h2;
  localparam logic [2:0] IDX_TRIGGER = 3'h3;
  localparam logic [2:0] IDX_IRQ_STATUS = 3'h4;
  localparam logic [2:0] IDX_IRQ_CLEAR = 3'h5;
  localparam logic [2:0] IDX_PIN_STATUS = 3'h6;
  // Modem control and feature bit positions
  localparam int MCR_RTS_BIT = 1;
  localparam int MCR_IRQ_DRIVE_BIT = 3;
  localparam int MCR_LOOP_BIT = 4;
  localparam int EFR_AUTO_RTS_BIT = 6;
  // Event bit positions in status, clear and enable
  localparam int EV_RX_READY = 0;
  localparam int EV_TX_ROOM = 1;
  localparam int EV_RX_ERROR = 2;
  localparam int EV_RING = 3;
  localparam int EV_W = 4;
  // Trigger field: level is field times step, zero means one
  localparam int TRIG_STEP = 4;
  // Values after reset
  localparam logic [7:0] MCR_RESET = 8'h00;
  localparam logic [7:0] EFR_RESET = 8'h00;
  localparam logic [7:0] TRIG_RESET = 8'h00;
  localparam logic [EV_W-1:0] IER_RESET = 4'h0;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

//--- src/chan_ctl_if.sv
// Control and status carried between the top and one channel front
`default_nettype none
interface chan_ctl_if;
  logic loopback;   // Local loopback mode for the channel
  logic ring_level; // Filtered ring indicator level
  logic ring_event; // One-cycle pulse on ring rising edge
  // Register side
  modport top (output loopback, input ring_level, input ring_event);
  // Pin side
  modport chan (input loopback, output ring_level, output ring_event);
endinterface
`default_nettype wire

//--- src/chan_pin_front.sv
// Serial and ring pin front end for one channel
`default_nettype none
module chan_pin_front
(
  input wire logic aclk,             // System clock
  input wire logic aresetn,          // Synchronous reset, active low
  chan_ctl_if.chan ctl,              // Link to register logic
  input wire logic tx_serial,        // Serial data from transmitter
  input wire logic rx_pin,           // Receive pin, asynchronous
  input wire logic ring_indicator_n, // Ring pin, asynchronous
  output logic tx_pin,               // Transmit pin
  output logic rx_to_receiver        // Serial data to receiver
);
  // Bit 0 is the receive pin, bit 1 the ring pin
  logic [1:0] pin_in;
  logic [1:0] s1_reg;
  logic [1:0] s2_reg;
  logic [1:0] s3_reg;
  logic [1:0] stable_reg;
  logic ring_prev_reg;

  assign pin_in = {ring_indicator_n, rx_pin};

  // Three-stage synchroniser; first stage feeds only the second
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_reg <= 2'h3;
      s2_reg <= 2'h3;
      s3_reg <= 2'h3;
    end
    else
    begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A change counts once stages two and three agree
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      stable_reg <= 2'h3;
    else
      stable_reg <= (~(s2_reg ^ s3_reg) & s2_reg)
                  | ((s2_reg ^ s3_reg) & stable_reg);
  end

  // Previous ring level for edge detection
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ring_prev_reg <= 1'b1;
    else
      ring_prev_reg <= stable_reg[1];
  end

  assign ctl.ring_event = stable_reg[1] & ~ring_prev_reg;
  assign ctl.ring_level = stable_reg[1];

  // Receiver input: idle during reset, own transmitter in loopback
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rx_to_receiver <= 1'b1;
    else if (ctl.loopback)
      rx_to_receiver <= tx_serial;
    else
      rx_to_receiver <= stable_reg[0];
  end

  // Transmit pin: idle during reset and while looped back
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tx_pin <= 1'b1;
    else if (ctl.loopback)
      tx_pin <= 1'b1;
    else
      tx_pin <= tx_serial;
  end
endmodule
`default_nettype wire

//--- src/dual_uart_pins.sv
// Dual serial channel pin behaviour with AXI4-Lite register access
//
// Our own choices: the AXI4-Lite register port and the register addresses.
`default_nettype none
// How it works
// - Bus write loads byte into addressed register
// - Drive bit set: interrupt driven, user output low
// - Drive bit clear: interrupt pin three-stated
// - Reset restores registers, idles serial pins
// - Ring pin rising edge raises modem event
// - Request bit set drives request-to-send low
// - Request-to-send high after reset
// - Auto request-to-send gates it by receive room
// - Loopback feeds transmit data into receiver
// - Loopback disconnects transmit pin
// - Receive-ready low on trigger or timeout
// - Receive-ready high once receive FIFO empty
// - Transmit-ready low when free space reaches trigger
// - Transmit-ready high when transmit buffer full
// - Channel interrupt needs drive bit, enable, pending
module dual_uart_pins
  import uart_pins_pkg::*;
(
  input wire logic aclk,                 // System clock, 50 MHz
  input wire logic aresetn,              // Synchronous reset, active low
  input wire logic [ADDR_W-1:0] awaddr,  // Write address
  input wire logic awvalid,              // Write address valid
  output logic awready,                  // Write address ready
  input wire logic [31:0] wdata,         // Write data
  input wire logic [3:0] wstrb,          // Write byte strobes
  input wire logic wvalid,               // Write data valid
  output logic wready,                   // Write data ready
  output logic [1:0] bresp,              // Write response
  output logic bvalid,                   // Write response valid
  input wire logic bready,               // Write response ready
  input wire logic [ADDR_W-1:0] araddr,  // Read address
  input wire logic arvalid,              // Read address valid
  output logic arready,                  // Read address ready
  output logic [31:0] rdata,             // Read data
  output logic [1:0] rresp,              // Read response
  output logic rvalid,                   // Read data valid
  input wire logic rready,               // Read data ready
  input wire logic [NUM_CH-1:0] tx_serial,        // From transmitters
  input wire logic [NUM_CH-1:0] rx_pin,           // Receive pins
  input wire logic [NUM_CH-1:0] ring_indicator_n, // Ring pins
  output logic [NUM_CH-1:0] tx_pin,               // Transmit pins
  output logic [NUM_CH-1:0] rx_to_receiver,       // To receivers
  output logic [NUM_CH-1:0] rts_n,                // Request-to-send
  output logic [NUM_CH-1:0] user_output,          // User outputs
  output logic [NUM_CH-1:0] channel_interrupt,    // Interrupt value
  output logic [NUM_CH-1:0] channel_interrupt_oe_n, // Low drives pin
  input wire logic [NUM_CH-1:0][LVL_W-1:0] rx_level, // RX FIFO fill
  input wire logic [NUM_CH-1:0] rx_timeout,       // RX timeout pulse
  input wire logic [NUM_CH-1:0] rx_error,         // RX error pulse
  input wire logic [NUM_CH-1:0][LVL_W-1:0] tx_free, // TX free spaces
  input wire logic [NUM_CH-1:0] rx_room,          // RX below halt
  output logic [NUM_CH-1:0] rx_dma_ready_n,       // Receive ready
  output logic [NUM_CH-1:0] tx_dma_ready_n,       // Transmit ready
  output logic irq                                // Summary interrupt
);
  // Channel picked by an address
  function automatic logic addr_chan(input logic [ADDR_W-1:0] a);
    addr_chan = a[CH_BIT];
  endfunction

  // Register index picked by an address
  function automatic logic [2:0] addr_idx(input logic [ADDR_W-1:0] a);
    addr_idx = a[4:2];
  endfunction

  // Trigger field to level; zero stands for one byte
  function automatic logic [LVL_W-1:0] trig_level(input logic [3:0] f);
    logic [LVL_W-1:0] lvl;
    lvl = LVL_W'(f) * LVL_W'(TRIG_STEP);
    if (f == 4'h0)
      lvl = LVL_W'(1);
    trig_level = lvl;
  endfunction

  // Write channel state
  logic aw_held_reg;                 // Write address taken
  logic w_held_reg;                  // Write data taken
  logic [ADDR_W-1:0] awaddr_reg;     // Held write address
  logic [7:0] wdata_reg;             // Held write byte
  logic wstrb0_reg;                  // Held lane 0 strobe
  logic do_write;                    // Both parts present
  logic wr_mapped;                   // Write index exists
  // Read channel state
  logic rd_mapped;                   // Read index exists
  logic [31:0] rd_val;               // Read mux result
  // Per channel registers
  logic [NUM_CH-1:0][7:0] mcr_reg;        // Modem control
  logic [NUM_CH-1:0][7:0] efr_reg;        // Enhanced feature
  logic [NUM_CH-1:0][EV_W-1:0] ier_reg;   // Interrupt enable
  logic [NUM_CH-1:0][7:0] trig_reg;       // Trigger levels
  logic [NUM_CH-1:0][EV_W-1:0] status_reg; // Sticky events
  logic [NUM_CH-1:0] pending;             // Enabled event set

  assign awready = ~aw_held_reg;
  assign wready = ~w_held_reg;
  assign arready = ~rvalid;
  assign do_write = aw_held_reg & w_held_reg & ~bvalid;
  assign wr_mapped = addr_idx(awaddr_reg) != 3'h7;
  assign rd_mapped = addr_idx(araddr) != 3'h7;

  // Write address capture, released when the write is done
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= '0;
    end
    else if (awvalid && awready)
    begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= awaddr;
    end
    else if (do_write)
      aw_held_reg <= 1'b0;
  end

  // Write data capture, in either order with the address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_reg <= 1'b0;
      wdata_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
    end
    else if (wvalid && wready)
    begin
      w_held_reg <= 1'b1;
      wdata_reg <= wdata[7:0];
      wstrb0_reg <= wstrb[0];
    end
    else if (do_write)
      w_held_reg <= 1'b0;
  end

  // Write response rises on the same edge as the register update
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid <= 1'b1;
      bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // Per channel logic, each picked by its value of the one select bit CH_BIT
  // independent channel copies
  for (genvar ch = 0; ch < NUM_CH; ch++)
  begin : g_ch
    chan_ctl_if ctl ();
    logic hit;         // Write lands in this channel
    logic [EV_W-1:0] events; // Event pulses this cycle
    logic [EV_W-1:0] clr;    // Bits cleared by software
    logic rx_go;       // Receive-ready condition
    logic tx_go;       // Transmit-ready condition
    logic [LVL_W-1:0] rx_trig; // Receive trigger level
    logic [LVL_W-1:0] tx_trig; // Transmit trigger level

    assign hit = do_write && wstrb0_reg
               && addr_chan(awaddr_reg) == 1'(ch);
    assign rx_trig = trig_level(trig_reg[ch][3:0]);
    assign tx_trig = trig_level(trig_reg[ch][7:4]);
    assign ctl.loopback = mcr_reg[ch][MCR_LOOP_BIT];

    // Pin front end: synchronisers, loopback, idle drive
    chan_pin_front u_front (
      .aclk(aclk),
      .aresetn(aresetn),
      .ctl(ctl.top),
      .tx_serial(tx_serial[ch]),
      .rx_pin(rx_pin[ch]),
      .ring_indicator_n(ring_indicator_n[ch]),
      .tx_pin(tx_pin[ch]),
      .rx_to_receiver(rx_to_receiver[ch])
    );

    // Software registers
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        mcr_reg[ch] <= MCR_RESET;
        efr_reg[ch] <= EFR_RESET;
        ier_reg[ch] <= IER_RESET;
        trig_reg[ch] <= TRIG_RESET;
      end
      else if (hit)
      begin
        unique case (addr_idx(awaddr_reg))
          IDX_MODEM_CTRL: mcr_reg[ch] <= wdata_reg;
          IDX_FEATURE: efr_reg[ch] <= wdata_reg;
          IDX_IRQ_ENABLE: ier_reg[ch] <= wdata_reg[EV_W-1:0];
          IDX_TRIGGER: trig_reg[ch] <= wdata_reg;
          default: ;
        endcase
      end
    end

    // Receive and transmit ready conditions
    assign rx_go = rx_level[ch] >= rx_trig || rx_timeout[ch];
    assign tx_go = tx_free[ch] >= tx_trig;

    // Events that set sticky status bits
    assign events[EV_RX_READY] = rx_go && rx_level[ch] != '0
                               && rx_dma_ready_n[ch];
    assign events[EV_TX_ROOM] = tx_go && tx_free[ch] != '0
                              && tx_dma_ready_n[ch];
    assign events[EV_RX_ERROR] = rx_error[ch];
    assign events[EV_RING] = ctl.ring_event;
    assign clr = (hit && addr_idx(awaddr_reg) == IDX_IRQ_CLEAR)
               ? wdata_reg[EV_W-1:0] : '0;

    // Sticky status; a new event beats a clear in the same cycle
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        status_reg[ch] <= '0;
      else
        status_reg[ch] <= (status_reg[ch] & ~clr) | events;
    end

    assign pending[ch] = |(status_reg[ch] & ier_reg[ch]);

    // Interrupt pin value and drive mode
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        channel_interrupt[ch] <= 1'b0;
        channel_interrupt_oe_n[ch] <= 1'b1;
      end
      else
      begin
        channel_interrupt[ch] <= mcr_reg[ch][MCR_IRQ_DRIVE_BIT]
                                 & pending[ch];
        channel_interrupt_oe_n[ch] <=
          ~mcr_reg[ch][MCR_IRQ_DRIVE_BIT];
      end
    end

    // User output follows the drive bit, low when set
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        user_output[ch] <= 1'b1;
      else
        user_output[ch] <= ~mcr_reg[ch][MCR_IRQ_DRIVE_BIT];
    end

    // Request-to-send from control bit and optional receive room
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        rts_n[ch] <= 1'b1;
      else
        rts_n[ch] <= ~(mcr_reg[ch][MCR_RTS_BIT]
                       & (~efr_reg[ch][EFR_AUTO_RTS_BIT]
                          | rx_room[ch]));
    end

    // Receive ready toward the DMA controller
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        rx_dma_ready_n[ch] <= 1'b1;
      else if (rx_level[ch] == '0)
        rx_dma_ready_n[ch] <= 1'b1;
      else if (rx_go)
        rx_dma_ready_n[ch] <= 1'b0;
    end

    // Transmit ready toward the DMA controller
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        tx_dma_ready_n[ch] <= 1'b1;
      else if (tx_free[ch] == '0)
        tx_dma_ready_n[ch] <= 1'b1;
      else if (tx_go)
        tx_dma_ready_n[ch] <= 1'b0;
    end
  end

  // Summary interrupt, high while any enabled status bit is set
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |pending;
  end

  // Read mux for the addressed channel and register
  always_comb
  begin
    logic c;
    c = addr_chan(araddr);
    rd_val = 32'h0000_0000;
    unique case (addr_idx(araddr))
      IDX_MODEM_CTRL: rd_val[7:0] = mcr_reg[c];
      IDX_FEATURE: rd_val[7:0] = efr_reg[c];
      IDX_IRQ_ENABLE: rd_val[EV_W-1:0] = ier_reg[c];
      IDX_TRIGGER: rd_val[7:0] = trig_reg[c];
      IDX_IRQ_STATUS: rd_val[EV_W-1:0] = status_reg[c];
      IDX_PIN_STATUS: rd_val[7:0] = {g_ch_ring(c), rx_room[c],
        mcr_reg[c][MCR_LOOP_BIT], tx_dma_ready_n[c],
        rx_dma_ready_n[c], rts_n[c], user_output[c],
        channel_interrupt[c]};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Filtered ring levels gathered for the read mux
  logic [NUM_CH-1:0] ring_levels;
  for (genvar ch = 0; ch < NUM_CH; ch++)
  begin : g_ring
    assign ring_levels[ch] = g_ch[ch].ctl.ring_level;
  end

  // Ring level of one channel
  function automatic logic g_ch_ring(input logic c);
    g_ch_ring = ring_levels[c];
  endfunction

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata <= rd_val;
      rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rready)
      rvalid <= 1'b0;
  end
endmodule
`default_nettype wire

//--- dv/dual_uart_pins_monitor.sv
// Port-level checks for the dual serial channel pin block
`default_nettype none
module dual_uart_pins_monitor
  import uart_pins_pkg::*;
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire logic awvalid, // Address valid
  input wire logic awready, // Address ready
  input wire logic wvalid, // Data valid
  input wire logic wready, // Data ready
  input wire logic bvalid, // Response valid
  input wire logic [NUM_CH-1:0] tx_serial, // Transmit data
  input wire logic [NUM_CH-1:0] tx_pin, // Transmit pins
  input wire logic [NUM_CH-1:0] rx_to_receiver, // Receiver input
  input wire logic [NUM_CH-1:0] rts_n, // Request-to-send
  input wire logic [NUM_CH-1:0] user_output, // User outputs
  input wire logic [NUM_CH-1:0] channel_interrupt, // Interrupt value
  input wire logic [NUM_CH-1:0] channel_interrupt_oe_n, // Drive enable
  input wire logic [NUM_CH-1:0][LVL_W-1:0] rx_level, // RX fill
  input wire logic [NUM_CH-1:0] rx_timeout, // RX timeout
  input wire logic [NUM_CH-1:0][LVL_W-1:0] tx_free, // TX room
  input wire logic [NUM_CH-1:0] rx_dma_ready_n, // Receive ready
  input wire logic [NUM_CH-1:0] tx_dma_ready_n // Transmit ready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Address and data taken on one edge
  sequence both_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  // Response shows two edges later
  sequence answer_due;
    ##2 bvalid;
  endsequence
  a_write_answer: assert property (both_taken |-> answer_due)
    else $error("write response not on time");
  a_reset_idle: assert property (
    $rose(aresetn) |-> rts_n == '1 && tx_pin == '1 &&
      rx_to_receiver == '1 && user_output == '1)
    else $error("outputs not idle after reset");
  a_drive_tie: assert property (
    channel_interrupt_oe_n == user_output)
    else $error("interrupt drive and user output disagree");
  a_irq_gate: assert property (
    (channel_interrupt & channel_interrupt_oe_n) == '0)
    else $error("interrupt high while three-stated");
  // Per-channel pin relations
  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    a_loop_path: assert property (
      $past(aresetn) |-> tx_pin[i] == $past(tx_serial[i]) ||
        tx_pin[i] && rx_to_receiver[i] == $past(tx_serial[i]))
      else $error("transmit path wrong");
    a_rx_empty: assert property (
      rx_level[i] == '0 |=> rx_dma_ready_n[i])
      else $error("receive ready not released");
    a_rx_timeout: assert property (
      rx_level[i] != '0 && rx_timeout[i] |=> !rx_dma_ready_n[i])
      else $error("receive ready missed timeout");
    a_tx_full: assert property (
      tx_free[i] == '0 |=> tx_dma_ready_n[i])
      else $error("transmit ready not released");
    a_tx_room: assert property (
      tx_free[i] >= 7'h3C |=> !tx_dma_ready_n[i])
      else $error("transmit ready missed room");
  end
endmodule
`default_nettype wire

//--- dv/far_side_model.sv
// Far-side stand-in: modem pins, transmitter data and FIFO levels
`default_nettype none
module far_side_model
  import uart_pins_pkg::*;
(
  input wire logic aclk, // System clock
  output logic [NUM_CH-1:0] tx_serial, // Transmitter data
  output logic [NUM_CH-1:0] rx_pin, // Modem transmit line
  output logic [NUM_CH-1:0] ring_indicator_n, // Ring pins
  output logic [NUM_CH-1:0][LVL_W-1:0] rx_level, // RX fill
  output logic [NUM_CH-1:0][LVL_W-1:0] tx_free, // TX room
  output logic [NUM_CH-1:0] rx_timeout, // Timeout pulse
  output logic [NUM_CH-1:0] rx_error, // Error pulse, unused
  output logic [NUM_CH-1:0] rx_room // Room below halt
);
  timeunit 1ns;
  timeprecision 1ps;
  // Lines idle high, receive FIFO empty, transmit FIFO full, room below halt set
  initial
  begin
    tx_serial = '1;
    rx_pin = '1;
    ring_indicator_n = '1;
    rx_level = '0;
    tx_free = '0;
    rx_timeout = '0;
    rx_error = '0;
    rx_room = '1;
  end
  // transmitter data, receive and ring pins move after an edge
  task automatic set_line(input int ch, input logic tx, rx, ring_n);
    @(posedge aclk);
    tx_serial[ch] <= tx;
    rx_pin[ch] <= rx;
    ring_indicator_n[ch] <= ring_n;
  endtask
  // FIFO fill, free space and room below halt
  task automatic set_fifo(input int ch, input logic [6:0] lvl, free,
                          input logic room);
    @(posedge aclk);
    rx_level[ch] <= lvl;
    tx_free[ch] <= free;
    rx_room[ch] <= room;
  endtask
  // One-cycle receive timeout
  task automatic pulse_to(input int ch);
    @(posedge aclk);
    rx_timeout[ch] <= 1'h1;
    @(posedge aclk);
    rx_timeout[ch] <= 1'h0;
  endtask
endmodule
`default_nettype wire

//--- dv/tb_dual_uart_pins.sv
// Self-checking bench for the dual serial channel pin block
`default_nettype none
module tb_dual_uart_pins
  import uart_pins_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'h0; // Clock
  logic aresetn = 1'h0; // Reset, active low
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0; // Addresses
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0; // Write strobes
  logic arvalid = 1'h0, rready = 1'h0; // Read strobes
  logic [31:0] wdata = '0; // Write data
  logic [3:0] wstrb = 4'h1; // Byte lane 0 only
  logic awready, wready, bvalid, arready, rvalid, irq; // Bus flags
  logic [1:0] bresp, rresp, rsp; // Responses
  logic [31:0] rdata, rd_val; // Read data
  logic [NUM_CH-1:0] tx_serial, rx_pin, ring_indicator_n, rx_timeout;
  logic [NUM_CH-1:0] rx_error, rx_room, tx_pin, rx_to_receiver, rts_n;
  logic [NUM_CH-1:0] user_output, channel_interrupt, channel_interrupt_oe_n;
  logic [NUM_CH-1:0] rx_dma_ready_n, tx_dma_ready_n; // DMA outputs
  logic [NUM_CH-1:0][LVL_W-1:0] rx_level, tx_free; // FIFO levels
  int miscompares = 0, check_count = 0; // Tallies
  // Register writes and the pin levels they give
  typedef struct packed {
    logic ch;
    logic [7:0] modem_control_reg;
    logic [7:0] enhanced_feature_reg;
    logic room;
    logic [2:0] exp;
  } row_t;
  // Expect is rts_n, user_output, drive enable
  row_t rows [6] = '{
    '{1'h0, 8'h02, 8'h00, 1'h1, 3'h3},
    '{1'h0, 8'h02, 8'h40, 1'h0, 3'h7},
    '{1'h0, 8'h02, 8'h40, 1'h1, 3'h3},
    '{1'h0, 8'h08, 8'h00, 1'h1, 3'h4},
    '{1'h1, 8'h0A, 8'h00, 1'h1, 3'h0},
    '{1'h0, 8'h00, 8'h00, 1'h1, 3'h7}
  };
  dual_uart_pins uut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .tx_serial,
    .rx_pin, .ring_indicator_n, .tx_pin, .rx_to_receiver, .rts_n,
    .user_output, .channel_interrupt, .channel_interrupt_oe_n, .rx_level,
    .rx_timeout, .rx_error, .tx_free, .rx_room, .rx_dma_ready_n,
    .tx_dma_ready_n, .irq);
  far_side_model far (.aclk, .tx_serial, .rx_pin, .ring_indicator_n,
    .rx_level, .tx_free, .rx_timeout, .rx_error, .rx_room);
  // 50 MHz clock
  always #10 aclk = ~aclk;
  // Compare and tally
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Let edges pass, end mid-cycle where outputs are settled
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  // Byte address of a channel register
  function automatic logic [5:0] adr(input logic ch, input logic [2:0] i);
    return {ch, i, 2'h0};
  endfunction
  // Bus write: release each channel once taken
  task automatic wr(input logic [5:0] a, input logic [7:0] d,
                    output logic [1:0] r);
    logic aw, w, b;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    b = 1'h0;
    while (!b)
    begin
      @(negedge aclk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw) awvalid <= 1'h0;
      if (w) wvalid <= 1'h0;
      if (b) bready <= 1'h0;
    end
  endtask
  // Bus read
  task automatic rd(input logic [5:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ar, v;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    v = 1'h0;
    while (!v)
    begin
      @(negedge aclk);
      ar = arvalid && arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar) arvalid <= 1'h0;
      if (v) rready <= 1'h0;
    end
  endtask
  // Counts, verdict, stop
  task automatic finish_test();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    finish_test();
  end
  // Main sequence
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    tick(1);
    chk("reset pins", {rts_n, user_output, channel_interrupt_oe_n, tx_pin,
      rx_to_receiver, rx_dma_ready_n, tx_dma_ready_n, irq,
      channel_interrupt}, 17'h1_FFF8);
    rd(adr(1'h0, IDX_MODEM_CTRL), rd_val, rsp);
    chk("mcr reset", rd_val, {24'h00_0000, MCR_RESET});
    foreach (rows[k])
    begin
      far.set_fifo(rows[k].ch, 7'h00, 7'h00, rows[k].room);
      wr(adr(rows[k].ch, IDX_MODEM_CTRL), rows[k].modem_control_reg, rsp);
      wr(adr(rows[k].ch, IDX_FEATURE), rows[k].enhanced_feature_reg, rsp);
      tick(2);
      chk("pins", {rts_n[rows[k].ch], user_output[rows[k].ch],
        channel_interrupt_oe_n[rows[k].ch]}, rows[k].exp);
    end
    chk("other ch", {rts_n[1], user_output[1]}, 2'h0);
    wr(adr(1'h0, 3'h7), 8'hFF, rsp);
    chk("bad wr", rsp, RESP_SLVERR);
    rd(adr(1'h0, 3'h7), rd_val, rsp);
    chk("bad rd", rd_val, 32'h0000_0000);
    chk("bad rd rsp", rsp, RESP_SLVERR);
    wr(adr(1'h0, IDX_MODEM_CTRL), 8'h10, rsp);
    far.set_line(0, 1'h0, 1'h1, 1'h1);
    tick(2);
    chk("loop", {tx_pin[0], rx_to_receiver[0]}, 2'h2);
    wr(adr(1'h0, IDX_MODEM_CTRL), 8'h00, rsp);
    tick(6);
    chk("no loop", {tx_pin[0], rx_to_receiver[0]}, 2'h1);
    far.set_line(0, 1'h1, 1'h1, 1'h1);
    far.set_fifo(0, 7'h05, 7'h40, 1'h1);
    tick(2);
    chk("dma on", {rx_dma_ready_n[0], tx_dma_ready_n[0]}, 2'h0);
    far.set_fifo(0, 7'h00, 7'h00, 1'h1);
    tick(2);
    chk("dma off", {rx_dma_ready_n[0], tx_dma_ready_n[0]}, 2'h3);
    wr(adr(1'h0, IDX_TRIGGER), 8'h02, rsp);
    far.set_fifo(0, 7'h03, 7'h00, 1'h1);
    tick(2);
    chk("below trig", rx_dma_ready_n[0], 1'h1);
    far.pulse_to(0);
    tick(2);
    chk("timeout", rx_dma_ready_n[0], 1'h0);
    wr(adr(1'h0, IDX_IRQ_ENABLE), 8'h08, rsp);
    wr(adr(1'h0, IDX_MODEM_CTRL), 8'h08, rsp);
    far.set_line(0, 1'h1, 1'h1, 1'h0);
    tick(6);
    far.set_line(0, 1'h1, 1'h1, 1'h1);
    tick(10);
    chk("ring irq", {irq, channel_interrupt[0]}, 2'h3);
    rd(adr(1'h0, IDX_IRQ_STATUS), rd_val, rsp);
    chk("ring bit", rd_val[EV_RING], 1'h1);
    wr(adr(1'h0, IDX_IRQ_ENABLE), 8'h00, rsp);
    tick(2);
    chk("masked", {irq, channel_interrupt[0]}, 2'h0);
    wr(adr(1'h0, IDX_IRQ_ENABLE), 8'h08, rsp);
    wr(adr(1'h0, IDX_MODEM_CTRL), 8'h00, rsp);
    tick(2);
    chk("not driven", {irq, channel_interrupt[0]}, 2'h2);
    wr(adr(1'h0, IDX_IRQ_CLEAR), 8'h08, rsp);
    tick(2);
    chk("cleared", irq, 1'h0);
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    tick(1);
    chk("rerun pins", {irq, rts_n[1], user_output[1]}, 3'h3);
    rd(adr(1'h1, IDX_MODEM_CTRL), rd_val, rsp);
    chk("rerun mcr", rd_val, {24'h00_0000, MCR_RESET});
    finish_test();
  end
endmodule
bind dual_uart_pins dual_uart_pins_monitor mon (.aclk, .aresetn, .awvalid,
  .awready, .wvalid, .wready, .bvalid, .tx_serial, .tx_pin, .rx_to_receiver,
  .rts_n, .user_output, .channel_interrupt, .channel_interrupt_oe_n,
  .rx_level, .rx_timeout, .tx_free, .rx_dma_ready_n, .tx_dma_ready_n);
`default_nettype wire
